// ---- verilog/fbs_defs.svh ----
// Constants for the flow-through burst SRAM access block.
// Assumes a single core clock; included by the fbs_sram_access module only.
`ifndef FBS_DEFS_SVH
`define FBS_DEFS_SVH

`define FBS_ADDR_W 20
`define FBS_LANES 4
`define FBS_LANE_BITS 8
`define FBS_FIFO_DEPTH 8
`define FBS_BURST_W 2
`define FBS_STEP_RESET 2'h0
`define FBS_FIRST_RESET 2'h0
`define FBS_SYNC_RESET 2'h0
`define FBS_PIN_SYNC_RESET 2'h3

`endif

// ---- verilog/fbs_pkg.sv ----
// Types shared by the burst SRAM access block.
// Assumes nothing beyond the constants header.
`default_nettype none
package fbs_pkg;
    typedef enum logic [2:0] {
        FBS_DESEL = 3'b001,
        FBS_READ  = 3'b010,
        FBS_WRITE = 3'b100
    } fbs_op_e;
endpackage
`default_nettype wire

// ---- verilog/fbs_fifo.sv ----
// Write buffer between the pin capture and the memory array.
// Assumes DEPTH is a power of two and one clock with active-low async reset.
`timescale 1ns/10ps
`default_nettype none
module fbs_fifo #(
    parameter int WIDTH = 60,
    parameter int DEPTH = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    assign o_in_ready = (count_reg != CW'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign o_out_data = store[rd_ptr_reg];

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            store[wr_ptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= push ? wr_ptr_reg + PW'(1) : wr_ptr_reg;
            rd_ptr_reg <= pop ? rd_ptr_reg + PW'(1) : rd_ptr_reg;
            count_reg <= count_reg + CW'(push) - CW'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- verilog/fbs_sram_access.sv ----
// Synchronous access control and array of a flow-through burst SRAM.
// Assumes the bus pins are synchronous to i_core_clk; enable and strap are not.
`timescale 1ns/10ps
`include "fbs_defs.svh"
`default_nettype none
module fbs_sram_access #(
    parameter int ADDR_W = `FBS_ADDR_W,
    parameter int LANES = `FBS_LANES,
    parameter int LANE_BITS = `FBS_LANE_BITS,
    parameter int FIFO_DEPTH = `FBS_FIFO_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_clock_qualifier_n,
    input wire logic i_chip_select_one_n,
    input wire logic i_chip_select_two,
    input wire logic i_chip_select_three_n,
    input wire logic i_advance_or_load,
    input wire logic i_write_n,
    input wire logic [LANES-1:0] i_byte_lane_select_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_output_enable_n,
    input wire logic i_burst_order_mode,
    input wire logic [LANES*LANE_BITS-1:0] i_data,
    output logic [LANES*LANE_BITS-1:0] o_data,
    output logic o_data_oe_n,
    input wire logic [LANES-1:0] i_parity_lines,
    output logic [LANES-1:0] o_parity_lines,
    output logic o_parity_lines_oe_n,
    output logic o_write_buffer_ready
);
    localparam int LW = LANE_BITS + 1;
    localparam int WW = LANES * LW;
    localparam int BW = `FBS_BURST_W;
    localparam int EW = ADDR_W + WW + LANES;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and asynchronous pins
    logic [1:0] rst_sync_reg;
    logic [1:0] oe_sync_reg;
    logic [1:0] mode_sync_reg;
    wire rst_n = rst_sync_reg[1];

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_reg <= `FBS_SYNC_RESET;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    // Output enable is resynchronised; costs two cycles of turn-on latency
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_sync_reg <= `FBS_PIN_SYNC_RESET;
            mode_sync_reg <= `FBS_PIN_SYNC_RESET;
        end else begin
            oe_sync_reg <= {oe_sync_reg[0], i_output_enable_n};
            mode_sync_reg <= {mode_sync_reg[0], i_burst_order_mode};
        end
    end
    wire oe_n = oe_sync_reg[1];
    wire mode_interleaved = mode_sync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [BW-1:0] burst_low(input logic inter,
                                                input logic [BW-1:0] first,
                                                input logic [BW-1:0] step);
        burst_low = inter ? (first ^ step) : BW'(first + step);
    endfunction

    function automatic logic [WW-1:0] merge(input logic [WW-1:0] old_word,
                                            input logic [WW-1:0] new_word,
                                            input logic [LANES-1:0] keep_n);
        merge = old_word;
        for (int k = 0; k < LANES; k++) begin
            if (!keep_n[k]) begin
                merge[k*LW +: LW] = new_word[k*LW +: LW];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Control decode
    wire qual = !i_clock_qualifier_n;
    wire selected = !i_chip_select_one_n && i_chip_select_two && !i_chip_select_three_n;
    wire load = qual && !i_advance_or_load;
    wire advance = qual && i_advance_or_load;

    fbs_pkg::fbs_op_e op_reg;
    fbs_pkg::fbs_op_e op_next;
    logic [ADDR_W-BW-1:0] base_reg;
    logic [BW-1:0] first_reg;
    logic [BW-1:0] step_reg;
    logic [BW-1:0] step_next;
    logic emerge_reg;

    assign op_next = !load ? op_reg :
                     !selected ? fbs_pkg::FBS_DESEL :
                     i_write_n ? fbs_pkg::FBS_READ : fbs_pkg::FBS_WRITE;
    assign step_next = load ? `FBS_STEP_RESET : advance ? step_reg + BW'(1) : step_reg;

    wire op_is_read = (op_reg == fbs_pkg::FBS_READ);
    wire op_is_write = (op_reg == fbs_pkg::FBS_WRITE);
    wire [ADDR_W-1:0] cur_addr = {base_reg, burst_low(mode_interleaved, first_reg, step_reg)};

    // Control and address pin sampling happens here, on the rising edge only
    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_reg <= fbs_pkg::FBS_DESEL;
            base_reg <= '0;
            first_reg <= `FBS_FIRST_RESET;
            step_reg <= `FBS_STEP_RESET;
            emerge_reg <= 1'b0;
        end else if (qual) begin
            op_reg <= op_next;
            step_reg <= step_next;
            emerge_reg <= (op_reg == fbs_pkg::FBS_DESEL) && (op_next != fbs_pkg::FBS_DESEL);
            if (load) begin
                base_reg <= i_addr[ADDR_W-1:BW];
                first_reg <= i_addr[BW-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path: data taken the edge after the address, buffered to the array
    logic [WW-1:0] pin_word;
    always_comb begin
        pin_word = '0;
        for (int k = 0; k < LANES; k++) begin
            pin_word[k*LW +: LW] = {i_parity_lines[k], i_data[k*LANE_BITS +: LANE_BITS]};
        end
    end

    wire enq_valid = qual && op_is_write;
    wire deq_valid;
    wire [EW-1:0] head;
    wire [ADDR_W-1:0] head_addr = head[EW-1 -: ADDR_W];
    wire [WW-1:0] head_word = head[LANES +: WW];
    wire [LANES-1:0] head_keep_n = head[LANES-1:0];

    // Drain stalls while suspended so the array also holds its state
    fbs_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_write_buffer (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_in_valid(enq_valid),
        .o_in_ready(o_write_buffer_ready),
        .i_in_data({cur_addr, pin_word, i_byte_lane_select_n}),
        .o_out_valid(deq_valid),
        .i_out_ready(qual),
        .o_out_data(head)
    );

    logic [WW-1:0] mem [2**ADDR_W];
    always_ff @(posedge i_core_clk) begin
        if (deq_valid && qual) begin
            mem[head_addr] <= merge(mem[head_addr], head_word, head_keep_n);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flow-through read with bypass of a write not yet in the array
    wire hit = deq_valid && (head_addr == cur_addr);
    wire [WW-1:0] rd_word = hit ? merge(mem[cur_addr], head_word, head_keep_n) : mem[cur_addr];
    wire drive = op_is_read && !emerge_reg && !oe_n;

    always_comb begin
        o_data = '0;
        o_parity_lines = '0;
        for (int k = 0; k < LANES; k++) begin
            o_data[k*LANE_BITS +: LANE_BITS] = rd_word[k*LW +: LANE_BITS];
            o_parity_lines[k] = rd_word[k*LW + LANE_BITS];
        end
    end
    assign o_data_oe_n = !drive;
    assign o_parity_lines_oe_n = !drive;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!rst_n);

    suspend_holds_a: assert property (!qual |=> $stable(op_reg) && $stable(step_reg)
        && $stable(base_reg))
        else $error("state moved while clock qualifier high");
    load_read_a: assert property (load && selected && i_write_n |=> op_is_read
        && base_reg == $past(i_addr[ADDR_W-1:BW]) && step_reg == 2'h0)
        else $error("read load did not register address");
    load_write_a: assert property (load && selected && !i_write_n |=> op_is_write
        ##0 o_data_oe_n)
        else $error("write load not taken as write");
    deselect_cycle_a: assert property (load && !selected |=>
        op_reg == fbs_pkg::FBS_DESEL && o_data_oe_n && o_parity_lines_oe_n)
        else $error("deselect did not float the bus");
    burst_step_a: assert property (advance |=> step_reg == $past(step_reg) + 2'h1
        && op_reg == $past(op_reg))
        else $error("burst counter did not step");
    burst_wrap_a: assert property (advance && step_reg == 2'h3 |=> step_reg == 2'h0)
        else $error("burst counter did not wrap after four");
    burst_order_a: assert property (advance && !mode_interleaved |=>
        cur_addr[BW-1:0] == BW'($past(cur_addr[BW-1:0]) + 2'h1))
        else $error("linear burst did not count up");
    burst_first_a: assert property (load |=> cur_addr[BW-1:0] == $past(i_addr[BW-1:0]))
        else $error("burst did not start at loaded address");
    write_capture_a: assert property (enq_valid && o_write_buffer_ready |=> deq_valid)
        else $error("write data not captured");
    emerge_float_a: assert property (qual && op_reg == fbs_pkg::FBS_DESEL && load && selected
        |=> o_data_oe_n)
        else $error("bus driven on first cycle after deselect");
    turnaround_a: assert property (qual && op_is_write && load && selected && i_write_n
        |=> op_is_read && deq_valid)
        else $error("read after write was delayed");
endmodule
`default_nettype wire

// ---- verif/fbs_ctrl_model.sv ----
// Memory controller model that owns every bus pin of the SRAM block.
// Assumes the bench calls its tasks; pins change at the falling edge only.
`timescale 1ns/10ps
`default_nettype none
module fbs_ctrl_model (
    input wire logic i_core_clk,
    output logic o_clock_qualifier_n,
    output logic o_chip_select_one_n,
    output logic o_chip_select_two,
    output logic o_chip_select_three_n,
    output logic o_advance_or_load,
    output logic o_write_n,
    output logic [3:0] o_byte_lane_select_n,
    output logic [7:0] o_addr,
    output logic o_output_enable_n,
    output logic o_burst_order_mode,
    output logic [31:0] o_data,
    output logic [3:0] o_parity_lines
);
    initial begin
        {o_chip_select_one_n, o_chip_select_two, o_chip_select_three_n} = 3'h6;
        {o_clock_qualifier_n, o_advance_or_load, o_write_n, o_addr} = 11'h100;
        {o_output_enable_n, o_burst_order_mode, o_byte_lane_select_n} = 6'h0f;
        {o_parity_lines, o_data} = 36'h0;
    end
    task automatic pins(input logic oe_n, input logic md);
        @(negedge i_core_clk);
        o_output_enable_n = oe_n;
        o_burst_order_mode = md;
    endtask
    // Released data lines flip each cycle so a stale word never looks valid
    task automatic beat(input logic q_n, input logic [2:0] cs, input logic adv,
                        input logic we_n, input logic [7:0] at, input logic dr,
                        input logic [35:0] wd, input logic [3:0] ln);
        @(negedge i_core_clk);
        o_clock_qualifier_n = q_n;
        {o_chip_select_one_n, o_chip_select_two, o_chip_select_three_n} = cs;
        o_advance_or_load = adv;
        o_write_n = we_n;
        o_addr = at;
        o_byte_lane_select_n = ln;
        {o_parity_lines, o_data} = dr ? wd : ~{o_parity_lines, o_data};
    endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the burst SRAM access block.
// Assumes the controller model owns the bus pins; bench owns clock and reset.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [2:0] SEL = 3'h2;
    localparam logic [2:0] DES = 3'h6;
    localparam logic [35:0] NIL = 36'h0;
    logic clk, rst_n, q_n, cs1_n, cs2, cs3_n, adv, we_n, oe_n, mode, oen, poen, rdy;
    logic [3:0] ln, pin, pout;
    logic [7:0] a;
    logic [31:0] din, dout;
    logic [35:0] mem [0:3];
    int err_count = 0;
    int checked = 0;

    fbs_ctrl_model i_fbs_ctrl_model (.i_core_clk(clk), .o_clock_qualifier_n(q_n),
        .o_chip_select_one_n(cs1_n), .o_chip_select_two(cs2), .o_chip_select_three_n(cs3_n),
        .o_advance_or_load(adv), .o_write_n(we_n), .o_byte_lane_select_n(ln), .o_addr(a),
        .o_output_enable_n(oe_n), .o_burst_order_mode(mode), .o_data(din),
        .o_parity_lines(pin));
    fbs_sram_access #(.ADDR_W(8)) i_fbs_sram_access (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_clock_qualifier_n(q_n), .i_chip_select_one_n(cs1_n), .i_chip_select_two(cs2),
        .i_chip_select_three_n(cs3_n), .i_advance_or_load(adv), .i_write_n(we_n),
        .i_byte_lane_select_n(ln), .i_addr(a), .i_output_enable_n(oe_n),
        .i_burst_order_mode(mode), .i_data(din), .o_data(dout), .o_data_oe_n(oen),
        .i_parity_lines(pin), .o_parity_lines(pout), .o_parity_lines_oe_n(poen),
        .o_write_buffer_ready(rdy));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_rd(input string what, input logic [35:0] exp);
        checked++;
        if ({pout, dout} !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, {pout, dout});
        end
    endtask
    task automatic chk_flag(input string what, input logic [1:0] exp, input logic [1:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [2:0] cs, input logic [7:0] at);
        i_fbs_ctrl_model.beat(1'h0, cs, 1'h0, 1'h1, at, 1'h0, NIL, 4'hf);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Writes carry the previous word's data, so read follows write with no gap
    task automatic s_back_to_back();
        i_fbs_ctrl_model.beat(1'h0, SEL, 1'h0, 1'h0, 8'h10, 1'h0, NIL, 4'hf);
        for (int k = 1; k < 5; k++) begin
            i_fbs_ctrl_model.beat(1'h0, SEL, 1'h0, k > 3, 8'h10 + 8'(k % 4), 1'h1, mem[k-1],
                                  4'h0);
            chk_flag("write phase enable", 2'h3, {oen, poen});
        end
        for (int k = 1; k < 5; k++) begin
            rd(k > 3 ? DES : SEL, 8'h10 + 8'(k % 4));
            chk_rd("read data", mem[k-1]);
            chk_flag("read enable", 2'h0, {oen, poen});
        end
        chk_flag("buffer ready", 2'h3, {2{rdy}});
    endtask
    task automatic s_lanes();
        i_fbs_ctrl_model.beat(1'h0, SEL, 1'h0, 1'h0, 8'h11, 1'h0, NIL, 4'hf);
        i_fbs_ctrl_model.beat(1'h0, SEL, 1'h0, 1'h1, 8'h11, 1'h1, 36'hf_ffff_ffff, 4'h5);
        rd(DES, 8'h00);
        mem[1] = mem[1] | 36'ha_ff00_ff00;
        chk_rd("lane merge", mem[1]);
    endtask
    // Step beats show the chip selects inactive, which must not matter
    task automatic s_burst(input logic md);
        logic [1:0] s;
        i_fbs_ctrl_model.pins(1'h0, md);
        repeat (3) rd(DES, 8'h00);
        rd(SEL, 8'h11);
        rd(SEL, 8'h11);
        chk_flag("first out of deselect", 2'h3, {oen, poen});
        // Start at one so linear and interleaved orders differ; last step wraps
        for (int k = 1; k < 7; k++) begin
            i_fbs_ctrl_model.beat(k == 2, DES, k != 2 && k != 6, 1'h0, 8'h21, 1'h0, NIL,
                                  4'hf);
            s = 2'(k - 1 - (k > 2 ? 1 : 0));
            chk_rd("burst data", mem[md ? 2'h1 ^ s : 2'h1 + s]);
            chk_flag("burst enable", 2'h0, {oen, poen});
        end
    endtask
    task automatic s_deselect();
        for (int j = 0; j < 3; j++) begin
            i_fbs_ctrl_model.beat(1'h0, SEL ^ 3'(1 << j), 1'h0, 1'h0, 8'h13, 1'h0, NIL,
                                  4'hf);
            i_fbs_ctrl_model.beat(1'h0, DES, 1'h0, 1'h1, 8'h13, 1'h1, NIL, 4'h0);
            chk_flag("deselected enable", 2'h3, {oen, poen});
        end
        rd(SEL, 8'h13);
        rd(SEL, 8'h13);
        rd(DES, 8'h13);
        chk_rd("untouched word", mem[3]);
    endtask
    task automatic s_enable();
        i_fbs_ctrl_model.pins(1'h1, 1'h0);
        repeat (3) rd(SEL, 8'h10);
        chk_flag("enable held off", 2'h3, {oen, poen});
        i_fbs_ctrl_model.pins(1'h0, 1'h0);
        repeat (3) rd(SEL, 8'h10);
        chk_flag("enable back on", 2'h0, {oen, poen});
        chk_rd("enabled read", mem[0]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'h0;
        for (int k = 0; k < 4; k++) begin
            mem[k] = {2'h0, 2'(k), 24'ha5c3e1, 6'h0, 2'(k)};
        end
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst_n = 1'h1;
        repeat (3) rd(DES, 8'h00);
        s_back_to_back();
        s_lanes();
        s_burst(1'h0);
        s_burst(1'h1);
        s_deselect();
        s_enable();
        conclude();
    end
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        conclude();
    end
endmodule
`default_nettype wire
